// [inc/vip_pkg.sv]
// Package of constants and types for the vectored interrupt pending logic
package vip_pkg;
	localparam int VIP_LEVELS = 8;
	localparam int VIP_SRC_HW = 4;
	localparam logic [7:0] VIP_TPF_ADDR = 8'hdd;
	localparam logic [7:0] VIP_STATUS_ADDR = 8'hdc;
	localparam logic [7:0] VIP_MASK_ADDR = 8'hfb;
	localparam logic [7:0] VIP_SYSMODE_ADDR = 8'hde;
	localparam logic [7:0] VIP_CTRL_ADDR = 8'h00;
	localparam logic [7:0] VIP_CSTAT_ADDR = 8'h01;
	localparam logic [7:0] VIP_CVEC_ADDR = 8'h02;
	localparam logic [7:0] VIP_TPF_RESET = 8'h00;
	localparam logic [7:0] VIP_MASK_RESET = 8'h00;
	localparam logic [7:0] VIP_TPF_WMASK = 8'h3f;
	localparam int VIP_GIE_BIT = 0;
	localparam logic [7:0] VIP_VEC_BASE = 8'h00;
	localparam logic [7:0] VIP_VEC_STRIDE = 8'h02;
	typedef enum logic [1:0] {
		VIP_CMD_NONE = 2'h0,
		VIP_CMD_INTERRUPT_RETURN_INSTRUCTION = 2'h1,
		VIP_CMD_EI = 2'h2,
		VIP_CMD_DI = 2'h3
	} vip_cmd_t;
	typedef enum logic [2:0] {
		VIP_ST_IDLE = 3'h0,
		VIP_ST_ACK = 3'h1,
		VIP_ST_PUSH_L = 3'h3,
		VIP_ST_PUSH_H = 3'h2,
		VIP_ST_PUSH_F = 3'h6,
		VIP_ST_VEC_H = 3'h7,
		VIP_ST_VEC_L = 3'h5,
		VIP_ST_JUMP = 3'h4
	} vip_state_t;
endpackage

// [inc/vip_if.sv]
// Interface joining interrupt logic and CPU core
`timescale 1ns/1ps
interface vip_if;
	logic req;
	logic [2:0] req_level;
	logic ack;
	logic [7:0] vec_addr;
	logic eoi;
	logic [1:0] cpu_cmd;
	logic cmd_valid;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic gie;
	modport dev (
		output req, req_level, vec_addr, rdata, gie,
		input ack, eoi, cpu_cmd, cmd_valid, wr, rd, addr, wdata
	);
	modport cpu (
		input req, req_level, vec_addr, rdata, gie,
		output ack, eoi, cpu_cmd, cmd_valid, wr, rd, addr, wdata
	);
endinterface

// [rtl/vip_device.sv]
// Interrupt pending, level request, eligibility and vectoring logic
`timescale 1ns/1ps
// Summary of operation
// RQ1 - Hardware-cleared flag sets, then request CPU
// RQ2 - Acknowledge clears hardware flags; unmapped
// RQ3 - Levels zero to three use hardware flags
// RQ4 - Other sources stay set until software
// RQ5 - Routine writes 0 before interrupt return
// RQ6 - Timer pending bits five down to zero
// RQ7 - Read one when pending; write zero clears
// RQ8 - Software writes zero to bits seven, six
// RQ9 - Disable globally before changing level mask
// RQ10 - Serve only enabled, unmasked, top, source-enabled
// RQ11 - Acknowledge only at instruction end
// RQ12 - Detect, check level, acknowledge, vector, clear
// RQ13 - Machine cycle clears global enable first
// RQ14 - Interrupt return sets global enable
// RQ15 - Push PCL, PCH, flags; fetch vector
// RQ16 - Vectors at even addresses, lowest page
// RQ17 - Nesting: push mask, new mask, enable
// RQ18 - Request status per level, zero at reset
// RQ19 - Highest level first; lower vector wins
// RQ20 - Writing one never sets timer flag
module vip_device
	import vip_pkg::*;
#(
	parameter int LEVELS = VIP_LEVELS
) (
	input wire logic I_CLK, // System clock
	input wire logic I_RST_N, // Synchronous reset, active low
	vip_if.dev bus, // Link to the CPU core
	input wire logic [VIP_SRC_HW-1:0] I_HW_EVT, // Hardware-cleared source events, level n
	input wire logic [5:0] I_TMR_EVT, // Timer pending events, flag layout
	input wire logic [LEVELS-1:0] I_SW_SRC, // Software-cleared pending levels
	input wire logic [LEVELS-1:0] I_SRC_EN // Source enables per level
);
	logic [VIP_SRC_HW-1:0] hw_pend_q;
	logic [5:0] tpf_q;
	logic [LEVELS-1:0] status_q;
	logic [7:0] mask_q;
	logic gie_q;
	logic req_q;
	logic [2:0] lvl_q;
	logic [7:0] vec_q;
	logic [7:0] rdata_q;
	logic ack_q;
	logic [LEVELS-1:0] raw_req;
	logic [LEVELS-1:0] elig;
	logic [2:0] top_lvl;
	logic any_elig;
	logic tpf_wr;
	logic mask_wr;
	logic [7:0] rd_mux;
	logic interrupt_return_instruction_cmd;
	logic ei_cmd;
	logic di_cmd;
	logic sel_tpf;
	logic sel_status;
	logic sel_mask;
	logic sel_sysmode;
	logic [VIP_SRC_HW-1:0] hw_clr;
	logic [5:0] tpf_clr;
	logic gie_d;
	logic req_d;
	logic lvl_upd;
	logic [7:0] vec_d;

	// Per-level request: hardware flag or software-held source
	genvar g;
	generate
		for (g = 0; g < LEVELS; g++) begin : g_lvl
			if (g < VIP_SRC_HW) begin : g_hw
				assign raw_req[g] = hw_pend_q[g] | I_SW_SRC[g]; // RQ3
			end else begin : g_sw
				assign raw_req[g] = I_SW_SRC[g]; // RQ4
			end
			assign elig[g] = raw_req[g] & mask_q[g] & I_SRC_EN[g] & gie_q; // RQ10
		end
	endgenerate

	// Fixed order: lowest level number is highest priority
	// A programmable ordering would change only this search
	// The level code is three bits, so at most eight levels are served
	always_comb begin
		top_lvl = 3'h0;
		any_elig = 1'b0;
		for (int i = LEVELS - 1; i >= 0; i--) begin
			if (elig[i]) begin
				top_lvl = 3'(i); // RQ19
				any_elig = 1'b1;
			end
		end
	end

	// Address selects, shared by the write and read paths
	assign sel_tpf = (bus.addr == VIP_TPF_ADDR);
	assign sel_status = (bus.addr == VIP_STATUS_ADDR);
	assign sel_mask = (bus.addr == VIP_MASK_ADDR);
	assign sel_sysmode = (bus.addr == VIP_SYSMODE_ADDR);

	// Register decode on the CPU side
	assign tpf_wr = bus.wr & sel_tpf;
	assign mask_wr = bus.wr & sel_mask;
	assign interrupt_return_instruction_cmd = bus.cmd_valid & (bus.cpu_cmd == VIP_CMD_INTERRUPT_RETURN_INSTRUCTION);
	assign ei_cmd = bus.cmd_valid & (bus.cpu_cmd == VIP_CMD_EI);
	assign di_cmd = bus.cmd_valid & (bus.cpu_cmd == VIP_CMD_DI);
	// Hardware flags are not in the map, so no read path exists
	// Status and system mode are read only; writes there are dropped
	assign rd_mux = sel_tpf ? {2'h0, tpf_q} : // RQ6
		sel_status ? 8'(status_q) : // RQ18
		sel_mask ? mask_q :
		sel_sysmode ? {7'h00, gie_q} : 8'h00; // RQ2

	// Clear strobes per flag; a set in the same cycle still wins below
	generate
		for (g = 0; g < VIP_SRC_HW; g++) begin : g_hwclr
			assign hw_clr[g] = ack_q & (lvl_q == 3'(g)); // RQ2
		end
		for (g = 0; g < 6; g++) begin : g_tpfclr
			assign tpf_clr[g] = tpf_wr & ~bus.wdata[g] & VIP_TPF_WMASK[g]; // RQ7 RQ20
		end
	endgenerate

	// Hardware-cleared flags: event set wins over acknowledge clear
	// A new event in the clear cycle keeps the flag, so none is lost
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			hw_pend_q <= '0;
		end else begin
			for (int i = 0; i < VIP_SRC_HW; i++) begin
				if (I_HW_EVT[i]) begin
					hw_pend_q[i] <= 1'b1; // RQ1
				end else if (hw_clr[i]) begin
					hw_pend_q[i] <= 1'b0; // RQ2
				end
			end
		end
	end

	// Timer flags: write 0 clears, write 1 ignored, event wins
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			tpf_q <= VIP_TPF_RESET[5:0];
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (I_TMR_EVT[i]) begin
					tpf_q[i] <= 1'b1; // RQ7
				end else if (tpf_clr[i]) begin
					tpf_q[i] <= 1'b0; // RQ7 RQ20
				end
			end
		end
	end

	// Mask, status and read data
	// Status shows raw requests, so software can poll levels that the
	// global enable or the mask holds off
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			mask_q <= VIP_MASK_RESET;
			status_q <= '0; // RQ18
			rdata_q <= 8'h00;
		end else begin
			if (mask_wr) begin
				mask_q <= bus.wdata;
			end
			status_q <= raw_req; // RQ18
			rdata_q <= bus.rd ? rd_mux : 8'h00;
		end
	end

	// Global enable: acknowledge clears it before the stacking begins;
	// clearing wins, so a return in the ack cycle cannot reopen the gate
	assign gie_d = (bus.ack | di_cmd) ? 1'b0 : // RQ13
		(interrupt_return_instruction_cmd | ei_cmd) ? 1'b1 : gie_q; // RQ14
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			gie_q <= 1'b0;
		end else begin
			gie_q <= gie_d;
		end
	end

	// Request held low in the ack cycle and the next, while the served
	// hardware flag is still being cleared; otherwise it would re-fire
	assign req_d = any_elig & ~bus.ack & ~ack_q; // RQ1
	// Level frozen during the ack so the clear hits the served flag
	assign lvl_upd = any_elig & ~bus.ack;
	// Vectors are two bytes apart, so every entry starts on an even byte
	assign vec_d = VIP_VEC_BASE + 8'({top_lvl, 1'b0}); // RQ16

	// Registered request to the CPU; level and vector track the top level, frozen in the ack cycle
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			req_q <= 1'b0;
			lvl_q <= 3'h0;
			vec_q <= VIP_VEC_BASE;
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus.ack; // RQ12
			req_q <= req_d; // RQ1
			if (lvl_upd) begin
				lvl_q <= top_lvl;
				vec_q <= vec_d; // RQ16
			end
		end
	end

	assign bus.req = req_q;
	assign bus.req_level = lvl_q;
	assign bus.vec_addr = vec_q;
	assign bus.rdata = rdata_q;
	assign bus.gie = gie_q;
endmodule

// [rtl/vip_cpu.sv]
// CPU-side interrupt sequencer: acknowledge, stacking and vector fetch
`timescale 1ns/1ps
module vip_cpu
	import vip_pkg::*;
(
	input wire logic I_CLK, // System clock
	input wire logic I_RST_N, // Synchronous reset, active low
	vip_if.cpu bus, // Link to the interrupt logic
	input wire logic I_INSTR_END, // Current instruction finishes
	input wire logic [15:0] I_PC, // Program counter to save
	input wire logic [7:0] I_FLAGS, // Flags to save
	input wire logic [7:0] I_ROM_DATA, // Vector byte from ROM
	input wire logic I_INTERRUPT_RETURN_INSTRUCTION, // Interrupt return executed
	input wire logic I_EI, // Enable instruction executed
	input wire logic I_DI, // Disable instruction executed
	input wire logic I_REG_WR, // Software register write
	input wire logic I_REG_RD, // Software register read
	input wire logic [7:0] I_REG_ADDR, // Software register address
	input wire logic [7:0] I_REG_WDATA, // Software write data
	output logic [7:0] O_REG_RDATA, // Read data, cycle after read
	output logic O_PUSH, // Stack push strobe
	output logic [7:0] O_PUSH_DATA, // Byte pushed
	output logic [7:0] O_ROM_ADDR, // Vector fetch address
	output logic O_JUMP, // Jump to service routine
	output logic [15:0] O_JUMP_ADDR, // Service routine address
	output logic O_BUSY // Interrupt machine cycle running
);
	vip_state_t st_q;
	vip_state_t st_d;
	logic [7:0] vh_q;
	logic [15:0] pc_q;
	logic [7:0] fl_q;
	logic [7:0] rom_q;
	logic push_q;
	logic [7:0] pdata_q;
	logic jump_q;
	logic [15:0] jaddr_q;
	logic busy_q;
	logic take;

	// Take only at instruction end
	assign take = (st_q == VIP_ST_IDLE) & bus.req & I_INSTR_END; // RQ11

	// Sequence: ack, push low, high, flags, vector high, low, jump
	always_comb begin
		case (st_q)
			VIP_ST_IDLE: st_d = take ? VIP_ST_ACK : VIP_ST_IDLE;
			VIP_ST_ACK: st_d = VIP_ST_PUSH_L;
			VIP_ST_PUSH_L: st_d = VIP_ST_PUSH_H;
			VIP_ST_PUSH_H: st_d = VIP_ST_PUSH_F;
			VIP_ST_PUSH_F: st_d = VIP_ST_VEC_H;
			VIP_ST_VEC_H: st_d = VIP_ST_VEC_L;
			VIP_ST_VEC_L: st_d = VIP_ST_JUMP;
			VIP_ST_JUMP: st_d = VIP_ST_IDLE;
			default: st_d = VIP_ST_IDLE;
		endcase
	end

	// Link drives; software port drives the register path in every state
	assign bus.ack = (st_q == VIP_ST_ACK); // RQ12 RQ13
	assign bus.eoi = I_INTERRUPT_RETURN_INSTRUCTION;
	assign bus.cmd_valid = I_INTERRUPT_RETURN_INSTRUCTION | I_EI | I_DI;
	assign bus.cpu_cmd = I_INTERRUPT_RETURN_INSTRUCTION ? VIP_CMD_INTERRUPT_RETURN_INSTRUCTION : I_EI ? VIP_CMD_EI :
		I_DI ? VIP_CMD_DI : VIP_CMD_NONE; // RQ14 RQ17
	assign bus.wr = I_REG_WR; // RQ5 RQ8 RQ9
	assign bus.rd = I_REG_RD;
	assign bus.addr = I_REG_ADDR;
	assign bus.wdata = I_REG_WDATA;

	// Sequencer registers
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			st_q <= VIP_ST_IDLE;
			pc_q <= 16'h0000;
			fl_q <= 8'h00;
			vh_q <= 8'h00;
			rom_q <= 8'h00;
			push_q <= 1'b0;
			pdata_q <= 8'h00;
			jump_q <= 1'b0;
			jaddr_q <= 16'h0000;
			busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			busy_q <= (st_d != VIP_ST_IDLE); // Registered so it tracks st_q
			push_q <= 1'b0;
			jump_q <= 1'b0;
			if (take) begin
				pc_q <= I_PC;
				fl_q <= I_FLAGS;
				rom_q <= bus.vec_addr; // RQ16
			end
			case (st_q)
				VIP_ST_PUSH_L: begin
					push_q <= 1'b1;
					pdata_q <= pc_q[7:0]; // RQ15
				end
				VIP_ST_PUSH_H: begin
					push_q <= 1'b1;
					pdata_q <= pc_q[15:8]; // RQ15
				end
				VIP_ST_PUSH_F: begin
					push_q <= 1'b1;
					pdata_q <= fl_q; // RQ15
				end
				VIP_ST_VEC_H: begin
					vh_q <= I_ROM_DATA; // RQ15
					rom_q <= rom_q + 8'h01;
				end
				VIP_ST_VEC_L: begin
					jump_q <= 1'b1;
					jaddr_q <= {vh_q, I_ROM_DATA}; // RQ15
				end
				default: begin
				end
			endcase
		end
	end

	// Read data lags the read by exactly one cycle
	assign O_REG_RDATA = bus.rdata;
	assign O_PUSH = push_q;
	assign O_PUSH_DATA = pdata_q;
	assign O_ROM_ADDR = rom_q;
	assign O_JUMP = jump_q;
	assign O_JUMP_ADDR = jaddr_q;
	assign O_BUSY = busy_q;
endmodule

// [verif/vip_checker.sv]
// Concurrent checks on the link between interrupt logic and CPU core
`timescale 1ns/1ps
module vip_checker
	import vip_pkg::*;
(
	input wire logic I_CLK, // System clock
	input wire logic I_RST_N, // Reset, active low
	input wire logic req, // Request to CPU
	input wire logic [2:0] req_level, // Level requested
	input wire logic ack, // Acknowledge pulse
	input wire logic [7:0] vec_addr, // Vector address
	input wire logic [1:0] cpu_cmd, // CPU command
	input wire logic cmd_valid, // Command strobe
	input wire logic eoi, // Return strobe
	input wire logic rd, // Read strobe
	input wire logic [7:0] addr, // Register address
	input wire logic [7:0] rdata, // Read data
	input wire logic gie // Global enable
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// Vector follows the level and stays even
	a_vec_even: assert property (req |-> vec_addr == {4'h0, req_level, 1'b0})
		else $error("vector not twice the level");
	a_ack_gie_off: assert property (ack |=> !gie)
		else $error("enable not cleared by acknowledge");
	a_ack_after_req: assert property (ack |-> $past(req) && $past(gie))
		else $error("acknowledge without enabled request");
	a_ack_one_cycle: assert property (ack |=> !ack)
		else $error("acknowledge longer than one cycle");
	a_interrupt_return_instruction_sets_gie: assert property (cmd_valid && cpu_cmd == VIP_CMD_INTERRUPT_RETURN_INSTRUCTION |=> gie)
		else $error("return did not set enable");
	a_di_clears_gie: assert property (cmd_valid && cpu_cmd == VIP_CMD_DI |=> !gie)
		else $error("disable did not clear enable");
	a_eoi_return: assert property (eoi |-> cmd_valid && cpu_cmd == VIP_CMD_INTERRUPT_RETURN_INSTRUCTION)
		else $error("return strobe without return command");
	// Read data tie back to the read that asked for them
	a_tpf_top_zero: assert property ($past(rd) && $past(addr) == VIP_TPF_ADDR |->
		rdata[7:6] == 2'h0) else $error("reserved flag bits not zero");
	a_gie_readback: assert property ($past(rd) && $past(addr) == VIP_SYSMODE_ADDR |->
		rdata[0] == $past(gie)) else $error("enable readback wrong");
	a_idle_rdata: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
endmodule

// [verif/testbench.sv]
// Self-checking bench joining interrupt logic and CPU sequencer
`timescale 1ns/1ps
module testbench;
	import vip_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, instr_end = 1'b0, interrupt_return_instruction = 1'b0, ei = 1'b0, di = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, push, jump, busy, jumped;
	logic [3:0] hw_evt = 4'h0;
	logic [5:0] tmr_evt = 6'h0;
	logic [7:0] sw_src = 8'h00, src_en = 8'h00, flags = 8'h00, reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, push_data, rom_addr, rom, d, w, m;
	logic [15:0] pc = 16'h0000, jump_addr, jaddr;
	logic [1:0] a;
	logic [7:0] pushes[$];
	int seed, errors, n_compared;
	vip_if u_vip_if();
	vip_device u_vip_device(.I_CLK(clk), .I_RST_N(rst_n), .bus(u_vip_if), .I_HW_EVT(hw_evt),
		.I_TMR_EVT(tmr_evt), .I_SW_SRC(sw_src), .I_SRC_EN(src_en));
	vip_cpu u_vip_cpu(.I_CLK(clk), .I_RST_N(rst_n), .bus(u_vip_if), .I_INSTR_END(instr_end),
		.I_PC(pc), .I_FLAGS(flags), .I_ROM_DATA(rom), .I_INTERRUPT_RETURN_INSTRUCTION(interrupt_return_instruction), .I_EI(ei), .I_DI(di),
		.I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
		.O_REG_RDATA(reg_rdata), .O_PUSH(push), .O_PUSH_DATA(push_data), .O_ROM_ADDR(rom_addr),
		.O_JUMP(jump), .O_JUMP_ADDR(jump_addr), .O_BUSY(busy));
	vip_checker u_vip_checker(.I_CLK(clk), .I_RST_N(rst_n), .req(u_vip_if.req),
		.req_level(u_vip_if.req_level), .ack(u_vip_if.ack), .vec_addr(u_vip_if.vec_addr),
		.cpu_cmd(u_vip_if.cpu_cmd), .cmd_valid(u_vip_if.cmd_valid), .rd(u_vip_if.rd),
		.eoi(u_vip_if.eoi), .addr(u_vip_if.addr), .rdata(u_vip_if.rdata), .gie(u_vip_if.gie));
	// Vector table contents, scrambled so high and low bytes differ
	function automatic logic [7:0] rom_f(input logic [7:0] x);
		return x ^ 8'ha5;
	endfunction
	assign rom = rom_f(rom_addr);
	always #12.5 clk = ~clk;
	// Stack pushes and jumps collected as they stand
	always @(posedge clk) begin
		if (push === 1'b1) pushes.push_back(push_data);
		if (jump === 1'b1) begin
			jumped = 1'b1;
			jaddr = jump_addr;
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] ad, input logic [7:0] dat);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= dat;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Data are taken in the cycle after the read strobe only
	task automatic rreg(input logic [7:0] ad);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// c: 0 return, 1 enable, 2 disable
	task automatic cmd(input int c);
		@(posedge clk);
		{interrupt_return_instruction, ei, di} <= 3'b100 >> c;
		@(posedge clk);
		{interrupt_return_instruction, ei, di} <= 3'b000;
	endtask
	// One instruction end; level l must be vectored when hit is set, and no jump must follow when hit is clear
	task automatic serve(input logic [7:0] l, input logic hit);
		logic [7:0] v;
		v = VIP_VEC_BASE + VIP_VEC_STRIDE * l;
		pushes = {};
		jumped = 1'b0;
		@(posedge clk);
		pc <= $random(seed);
		flags <= $random(seed);
		instr_end <= 1'b1;
		@(posedge clk);
		instr_end <= 1'b0;
		#1 cmp(busy, hit, "busy on take");
		repeat (20) @(posedge clk);
		cmp(busy, 1'b0, "busy after jump");
		cmp(jumped, hit, "jump");
		if (hit) begin
			cmp(jaddr, {rom_f(v), rom_f(v + 8'h01)}, "vector");
			cmp(16'(pushes.size()), 16'h3, "push count");
			cmp({pushes[0], pushes[1], pushes[2]}, {pc[7:0], pc[15:8], flags}, "stack");
		end
	endtask
	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog sized well above the few hundred cycles of the run
	initial begin
		#100000;
		errors++;
		$display("[ERR] %0t watchdog", $time);
		conclude();
	end
	initial begin
		seed = 32'h20f0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rreg(VIP_TPF_ADDR);
		cmp(d, VIP_TPF_RESET, "flags reset");
		rreg(VIP_STATUS_ADDR);
		cmp(d, 8'h00, "status reset");
		rreg(VIP_MASK_ADDR);
		cmp(d, VIP_MASK_RESET, "mask reset");
		rreg(8'h55);
		cmp(d, 8'h00, "unmapped");
		$display("test reset done");
		// Random timer events, writes of one ignored, writes of zero clear
		for (int i = 0; i < 6; i++) begin
			m = $random(seed);
			w = $random(seed) & 8'h3f;
			@(posedge clk);
			tmr_evt <= m[5:0];
			@(posedge clk);
			tmr_evt <= 6'h0;
			wreg(VIP_TPF_ADDR, 8'h3f);
			rreg(VIP_TPF_ADDR);
			cmp(d, {2'h0, m[5:0]}, "flags set");
			wreg(VIP_TPF_ADDR, w);
			rreg(VIP_TPF_ADDR);
			cmp(d, {2'h0, m[5:0] & w[5:0]}, "flags clear");
			wreg(VIP_TPF_ADDR, 8'h00);
		end
		$display("test timer flags done");
		src_en <= 8'hff;
		wreg(VIP_MASK_ADDR, 8'hff);
		cmd(1);
		a = (m[1:0] == 2'h3) ? 2'h2 : m[1:0];
		@(posedge clk);
		hw_evt <= 4'h8 | (4'h1 << a);
		sw_src <= 8'h40;
		@(posedge clk);
		hw_evt <= 4'h0;
		repeat (8) @(posedge clk);
		cmp(busy, 1'b0, "busy before end");
		rreg(VIP_STATUS_ADDR);
		cmp(d, 8'h48 | (8'h01 << a), "status");
		serve({6'h0, a}, 1'b1);
		rreg(VIP_SYSMODE_ADDR);
		cmp(d[0], 1'b0, "enable off");
		serve(8'h3, 1'b0);
		cmd(0);
		rreg(VIP_STATUS_ADDR);
		cmp(d, 8'h48, "hw flag cleared");
		serve(8'h3, 1'b1);
		cmd(0);
		serve(8'h6, 1'b1);
		cmd(0);
		rreg(VIP_STATUS_ADDR);
		cmp(d, 8'h40, "sw flag held");
		cmd(2);
		wreg(VIP_MASK_ADDR, 8'h00);
		cmd(1);
		rreg(VIP_SYSMODE_ADDR);
		cmp(d[0], 1'b1, "enable on");
		serve(8'h6, 1'b0);
		sw_src <= 8'h00;
		cmd(2);
		rreg(VIP_SYSMODE_ADDR);
		cmp(d[0], 1'b0, "disable");
		$display("test vectoring done");
		conclude();
	end
endmodule
